// >>> core/dtr_edge_sync.sv
// Purpose: three-stage synchroniser and edge detector for one pin
// Assumes: pin is asynchronous to pclk
// Notes:   a change counts once stages two and three agree
`timescale 1ns/1ps
module dtr_edge_sync
  import dtr_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pin,
  output dtr_pin_s  pin_q
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  // first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_q <= '0;
    end else begin
      pin_q.rise <= 1'b0;
      pin_q.fall <= 1'b0;
      if (s2_q == s3_q && s3_q != pin_q.level) begin
        pin_q.level <= s3_q;
        pin_q.rise  <= s3_q;
        pin_q.fall  <= ~s3_q;
      end
    end
  end

endmodule

// >>> core/dtr_pkg.sv
// Purpose: shared constants, types and decode for the dual reload timer
// Assumes: 32-bit apb data, one register per aligned word
// Notes:   all offsets are byte addresses
package dtr_pkg;

  // ---------------------------------------------------------------
  // clock and instruction-cycle rate
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int TC_PERIOD_NS  = 1;
  localparam int TC_PERIOD_US  = TC_PERIOD_NS * 1000;
  localparam int TC_CYCLES     = TC_PERIOD_US * 1000 / CLK_PERIOD_PS;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int          ADDR_W       = 8;
  localparam int          CNT_W        = 16;
  localparam int          CTRL_W       = 8;
  localparam logic [7:0]  OFS_CTRL     = 8'h00;
  localparam logic [7:0]  OFS_COUNT    = 8'h04;
  localparam logic [7:0]  OFS_RELOAD_A = 8'h08;
  localparam logic [7:0]  OFS_RELOAD_B = 8'h0c;
  localparam logic [7:0]  OFS_IRQ      = 8'h10;

  // control register fields, bit 7 down to bit 0
  localparam int BIT_MODE_HI = 7;
  localparam int BIT_MODE_LO = 5;
  localparam int BIT_RUN     = 4;
  localparam int BIT_PEND_A  = 3;
  localparam int BIT_EN_A    = 2;
  localparam int BIT_PEND_B  = 1;
  localparam int BIT_EN_B    = 0;

  localparam logic [CTRL_W-1:0] CTRL_RST  = 8'h00;
  localparam logic [CNT_W-1:0]  CNT_RST   = 16'h0000;
  localparam logic [CNT_W-1:0]  CNT_ZERO  = 16'h0000;
  localparam logic [CNT_W-1:0]  CNT_ONE   = 16'h0001;
  localparam logic [31:0]       DATA_ZERO = 32'h0000_0000;

  // mode select encodings
  localparam logic [2:0] MODE_PWM_TGL = 3'b101;
  localparam logic [1:0] MODE_PWM_HI2 = 2'b10;
  localparam logic [1:0] MODE_EVT_HI2 = 2'b00;

  typedef struct packed {
    logic pwm;
    logic toggle;
    logic evt;
    logic evt_fall;
    logic cap;
    logic cap_a_fall;
    logic cap_b_fall;
  } dtr_mode_s;

  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } dtr_pin_s;

  function automatic dtr_mode_s dtr_decode(input logic [2:0] m);
    dtr_mode_s r;
    r.pwm        = (m[2:1] == MODE_PWM_HI2);
    r.toggle     = (m == MODE_PWM_TGL);
    r.evt        = (m[2:1] == MODE_EVT_HI2);
    r.evt_fall   = r.evt & m[0];
    r.cap        = m[1];
    r.cap_a_fall = m[0];
    r.cap_b_fall = m[2] | m[0];
    return r;
  endfunction

  function automatic logic dtr_edge(input dtr_pin_s p, input logic fall);
    return fall ? p.fall : p.rise;
  endfunction

endpackage

// >>> core/dtr_tick_div.sv
// Purpose: divides pclk down to a one-cycle instruction-cycle enable
// Assumes: single clock domain
// Notes:   tick_q is high for one pclk cycle every DIV cycles
`timescale 1ns/1ps
module dtr_tick_div
  import dtr_pkg::*;
#(
  parameter int DIV = TC_CYCLES
) (
  input  wire logic pclk,
  input  wire logic presetn,
  output logic      tick_q
);

  localparam logic [15:0] LAST = 16'(DIV - 1);

  logic [15:0] cnt_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q  <= 16'h0000;
      tick_q <= 1'b0;
    end else if (cnt_q == LAST) begin
      cnt_q  <= 16'h0000;
      tick_q <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 16'h0001;
      tick_q <= 1'b0;
    end
  end

endmodule

// >>> core/dtr_timer.sv
// Purpose: 16-bit timer with two reload/capture registers and two pins
// Assumes: apb slave, no wait states, pready registered from the setup cycle
// Notes:   pwm, external event counting and input capture modes
//
// Notes on behaviour
// - event mode counts edges of pin a, polarity from mode bits
// - event mode underflow sets pending a; irq a when enable a set
// - event mode rising edge on pin b sets pending b
// - event mode never drives pin a
// - capture mode: counter free-runs at tick rate, no reload
// - capture edge on pin a copies count to reg a; pin b to reg b
// - capture polarity set per pin by mode bits; pin a falling forces pin b falling
// - capture edges set pending a or b; irq needs its enable
// - capture mode underflow sets run bit as underflow pending
// - capture irq a is or of pending a and underflow pending
// - pwm and event modes count only while run bit is one
// - each enable flag passes its interrupt when one
// - mode 101 pwm toggling, 100 pwm quiet, 000/001 event counting
// - 010, 110, 011, 111 select capture edge polarities
// - pwm: first underflow reloads reg a, then b, a alternately
// - pwm reload from a sets pending a; from b sets pending b
// - control bits 7..0: mode 7..5, run, pend a, en a, pend b, en b
`timescale 1ns/1ps
module dtr_timer
  import dtr_pkg::*;
#(
  parameter int TC_DIV = TC_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        timer_pin_a_i,
  output logic             timer_pin_a_o,
  output logic             timer_pin_a_oe,
  input  wire logic        timer_pin_b_i,
  output logic             irq_a,
  output logic             irq_b
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl_q;
  logic [CNT_W-1:0]  count_q;
  logic [CNT_W-1:0]  reload_capture_reg_a_q;
  logic [CNT_W-1:0]  reload_capture_reg_b_q;
  logic              next_from_a_q;
  logic              pin_a_level_q;

  logic              tick;
  dtr_pin_s          pin_a;
  dtr_pin_s          pin_b;
  dtr_mode_s         mode;

  // ---------------------------------------------------------------
  // instruction-cycle enable and pin synchronisers
  // ---------------------------------------------------------------
  dtr_tick_div #(
    .DIV     (TC_DIV)
  ) u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .tick_q  (tick)
  );

  dtr_edge_sync u_sync_a (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (timer_pin_a_i),
    .pin_q   (pin_a)
  );

  dtr_edge_sync u_sync_b (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (timer_pin_b_i),
    .pin_q   (pin_b)
  );

  // ---------------------------------------------------------------
  // mode decode and control field views
  // ---------------------------------------------------------------
  logic run_or_underflow_flag;
  logic pending_flag_a;
  logic irq_enable_a;
  logic pending_flag_b;
  logic irq_enable_b;

  always_comb begin
    mode                  = dtr_decode(ctrl_q[BIT_MODE_HI:BIT_MODE_LO]);
    run_or_underflow_flag = ctrl_q[BIT_RUN];
    pending_flag_a        = ctrl_q[BIT_PEND_A];
    irq_enable_a          = ctrl_q[BIT_EN_A];
    pending_flag_b        = ctrl_q[BIT_PEND_B];
    irq_enable_b          = ctrl_q[BIT_EN_B];
  end

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  logic setup;
  logic access_done;
  logic wr;
  logic wr_ctrl;
  logic wr_count;
  logic wr_ra;
  logic wr_rb;
  logic mapped;

  always_comb begin
    setup       = psel & ~penable;
    access_done = psel & penable & pready;
    wr          = access_done & pwrite;
    wr_ctrl     = wr & (paddr == OFS_CTRL);
    wr_count    = wr & (paddr == OFS_COUNT);
    wr_ra       = wr & (paddr == OFS_RELOAD_A);
    wr_rb       = wr & (paddr == OFS_RELOAD_B);
    mapped      = (paddr == OFS_CTRL)     | (paddr == OFS_COUNT) |
                  (paddr == OFS_RELOAD_A) | (paddr == OFS_RELOAD_B) |
                  (paddr == OFS_IRQ);
  end

  // ---------------------------------------------------------------
  // counting step and underflow
  // ---------------------------------------------------------------
  logic step;
  logic underflow;
  logic cap_a;
  logic cap_b;
  logic evt_b;
  logic reload_a;
  logic reload_b;

  always_comb begin
    step = 1'b0;
    if (mode.pwm) begin
      step = tick & run_or_underflow_flag;
    end else if (mode.evt) begin
      step = run_or_underflow_flag &
             dtr_edge(pin_a, mode.evt_fall);
    end else begin
      step = tick;
    end
    underflow = step & (count_q == CNT_ZERO);
    reload_a  = underflow & mode.pwm & next_from_a_q;
    reload_b  = underflow & mode.pwm & ~next_from_a_q;
    cap_a     = mode.cap & dtr_edge(pin_a, mode.cap_a_fall);
    cap_b     = mode.cap & dtr_edge(pin_b, mode.cap_b_fall);
    evt_b     = mode.evt & pin_b.rise;
  end

  // ---------------------------------------------------------------
  // main counter
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= CNT_RST;
    end else if (wr_count) begin
      count_q <= pwpdata_cnt(pwdata);
    end else if (reload_a) begin
      count_q <= reload_capture_reg_a_q;
    end else if (reload_b) begin
      count_q <= reload_capture_reg_b_q;
    end else if (underflow & mode.evt) begin
      count_q <= reload_capture_reg_a_q;
    end else if (step) begin
      // capture mode wraps from zero to all ones, no reload
      count_q <= count_q - CNT_ONE;
    end
  end

  function automatic logic [CNT_W-1:0] pwpdata_cnt(input logic [31:0] d);
    return d[CNT_W-1:0];
  endfunction

  // ---------------------------------------------------------------
  // reload alternation
  // ---------------------------------------------------------------
  // a change of mode or run bit restarts the sequence at register a,
  // so the first underflow after starting always reloads from a
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      next_from_a_q <= 1'b1;
    end else if (wr_ctrl &&
                 pwdata[BIT_MODE_HI:BIT_RUN] !=
                 ctrl_q[BIT_MODE_HI:BIT_RUN]) begin
      next_from_a_q <= 1'b1;
    end else if (reload_a | reload_b) begin
      next_from_a_q <= ~next_from_a_q;
    end
  end

  // ---------------------------------------------------------------
  // reload / capture registers
  // ---------------------------------------------------------------
  // a capture in the same cycle as a software write wins, so the
  // measured edge is never lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_capture_reg_a_q <= CNT_RST;
    end else if (cap_a) begin
      reload_capture_reg_a_q <= count_q;
    end else if (wr_ra) begin
      reload_capture_reg_a_q <= pwdata[CNT_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_capture_reg_b_q <= CNT_RST;
    end else if (cap_b) begin
      reload_capture_reg_b_q <= count_q;
    end else if (wr_rb) begin
      reload_capture_reg_b_q <= pwdata[CNT_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // control register with hardware-set flags
  // ---------------------------------------------------------------
  logic set_a;
  logic set_b;
  logic set_uf;

  always_comb begin
    set_a  = reload_a | (underflow & mode.evt) | cap_a;
    set_b  = reload_b | evt_b | cap_b;
    set_uf = underflow & mode.cap;
  end

  // hardware sets win over a software clear in the same cycle;
  // nothing here ever clears a flag except a write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= pwdata[CTRL_W-1:0];
      end
      if (set_a) begin
        ctrl_q[BIT_PEND_A] <= 1'b1;
      end
      if (set_b) begin
        ctrl_q[BIT_PEND_B] <= 1'b1;
      end
      if (set_uf) begin
        ctrl_q[BIT_RUN] <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // pin a output
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_a_level_q <= 1'b0;
    end else if (underflow & mode.toggle) begin
      pin_a_level_q <= ~pin_a_level_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_pin_a_o  <= 1'b0;
      timer_pin_a_oe <= 1'b0;
    end else begin
      timer_pin_a_o  <= pin_a_level_q;
      // only the toggling pwm mode drives the pin
      timer_pin_a_oe <= mode.toggle;
    end
  end

  // ---------------------------------------------------------------
  // interrupt requests
  // ---------------------------------------------------------------
  logic irq_a_d;
  logic irq_b_d;

  always_comb begin
    irq_a_d = irq_enable_a &
              (pending_flag_a |
               (mode.cap & run_or_underflow_flag));
    irq_b_d = irq_enable_b & pending_flag_b;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_a <= 1'b0;
      irq_b <= 1'b0;
    end else begin
      irq_a <= irq_a_d;
      irq_b <= irq_b_d;
    end
  end

  // ---------------------------------------------------------------
  // apb answer
  // ---------------------------------------------------------------
  // read data are sampled in the setup cycle, one cycle before the
  // transfer completes; pready follows setup, so no access has a wait state
  logic [31:0] rdata_d;

  always_comb begin
    rdata_d = DATA_ZERO;
    unique case (paddr)
      OFS_CTRL:     rdata_d[CTRL_W-1:0] = ctrl_q;
      OFS_COUNT:    rdata_d[CNT_W-1:0]  = count_q;
      OFS_RELOAD_A: rdata_d[CNT_W-1:0]  = reload_capture_reg_a_q;
      OFS_RELOAD_B: rdata_d[CNT_W-1:0]  = reload_capture_reg_b_q;
      OFS_IRQ:      rdata_d[1:0]        = {irq_b, irq_a};
      default:      rdata_d             = DATA_ZERO;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= DATA_ZERO;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      if (setup) begin
        prdata <= pwrite ? DATA_ZERO : rdata_d;
      end
    end
  end

endmodule

// >>> verification/dtr_pin_model.sv
// Purpose: far side of the two timer pins
// Assumes: pins change only just after a pclk edge
// Notes:   pin a resolves device drive against this model
`timescale 1ns/1ps
module dtr_pin_model
  import dtr_pkg::*;
(
  input  wire logic pclk,
  input  wire logic pin_a_o,
  input  wire logic pin_a_oe,
  output logic      pin_a,
  output logic      pin_b
);
  logic drv_a;

  // the device wins while it drives; the model only fills a released pin
  assign pin_a = pin_a_oe ? pin_a_o : drv_a;

  initial begin
    drv_a = 1'b0;
    pin_b = 1'b0;
  end

  // levels held 8 cycles: shorter pulses may be lost in the synchroniser
  task automatic set_pins(input logic a, input logic b);
    @(posedge pclk);
    drv_a <= a;
    pin_b <= b;
    repeat (8) @(posedge pclk);
  endtask
endmodule

// >>> verification/dtr_timer_chk.sv
// Purpose: port-level checks on the timer
// Assumes: control writes seen on the apb port
// Notes:   shadows the mode and enable bits from bus writes
`timescale 1ns/1ps
module dtr_timer_chk
  import dtr_pkg::*;
#(
  parameter int TC_DIV = TC_CYCLES
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        timer_pin_a_i,
  input wire logic        timer_pin_a_o,
  input wire logic        timer_pin_a_oe,
  input wire logic        timer_pin_b_i,
  input wire logic        irq_a,
  input wire logic        irq_b
);
  logic [2:0] mode_q;
  logic       en_a_q;
  logic       en_b_q;
  logic       wr_ctrl;

  assign wr_ctrl = psel && penable && pready && pwrite && paddr == OFS_CTRL;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= 3'h0;
      en_a_q <= 1'b0;
      en_b_q <= 1'b0;
    end else if (wr_ctrl) begin
      mode_q <= pwdata[7:5];
      en_a_q <= pwdata[2];
      en_b_q <= pwdata[0];
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_pready_wait: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_pready_access: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  a_err_unmapped: assert property (pready && paddr > 8'h10 |-> pslverr)
    else $error("no error on unmapped address");
  a_err_mapped: assert property
    (pready && paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10} |-> !pslverr)
    else $error("error on mapped address");
  a_rd_upper: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0)
    else $error("upper read bits set");
  a_oe_quiet: assert property ((mode_q != MODE_PWM_TGL) [*2] |-> !timer_pin_a_oe)
    else $error("pin a driven outside toggle mode");
  a_oe_drive: assert property ((mode_q == MODE_PWM_TGL) [*2] |-> timer_pin_a_oe)
    else $error("pin a not driven in toggle mode");
  a_irq_a_gate: assert property (!en_a_q [*2] |-> !irq_a)
    else $error("irq a while disabled");
  a_irq_b_gate: assert property (!en_b_q [*2] |-> !irq_b)
    else $error("irq b while disabled");

  c_irq_a: cover property ($rose(irq_a));
  c_irq_b: cover property ($rose(irq_b));
  c_err: cover property (pready && pslverr);
  c_oe: cover property ($rose(timer_pin_a_oe));
endmodule

bind dtr_timer dtr_timer_chk #(.TC_DIV(TC_DIV)) u_chk (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .timer_pin_a_i, .timer_pin_a_o, .timer_pin_a_oe, .timer_pin_b_i,
  .irq_a, .irq_b);

// >>> verification/dual_reload_timer_block_tb_top.sv
// Purpose: self-checking bench for the dual reload timer
// Assumes: instruction tick shortened to 4 pclk
// Notes:   table of register cases, then mode scenarios
`timescale 1ns/1ps
module dual_reload_timer_block_tb_top
  import dtr_pkg::*;
();
  localparam int DIV = 4;
  typedef struct {
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] q;
    logic        e;
  } dtr_row_s;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, keep;
  logic        timer_pin_a_i, timer_pin_a_o, timer_pin_a_oe, timer_pin_b_i;
  logic        irq_a, irq_b, fa, fb;
  int          n_errors, check_count;
  real         t0;
  logic [2:0]  caps [4] = '{3'b010, 3'b110, 3'b011, 3'b111};
  dtr_row_s    rows [6] = '{
    '{OFS_COUNT, 32'hffff_1234, 32'h0000_1234, 1'b0},
    '{OFS_RELOAD_A, 32'h0000_00a5, 32'h0000_00a5, 1'b0},
    '{OFS_RELOAD_B, 32'h0000_5a00, 32'h0000_5a00, 1'b0},
    '{OFS_CTRL, 32'h0000_0005, 32'h0000_0005, 1'b0},
    '{OFS_IRQ, 32'hffff_ffff, 32'h0000_0000, 1'b0},
    '{8'h14, 32'h0000_0077, 32'h0000_0000, 1'b1}};

  dtr_timer #(.TC_DIV(DIV)) DUT (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .timer_pin_a_i,
    .timer_pin_a_o, .timer_pin_a_oe, .timer_pin_b_i, .irq_a, .irq_b);
  dtr_pin_model u_pins (.pclk, .pin_a_o(timer_pin_a_o),
    .pin_a_oe(timer_pin_a_oe), .pin_a(timer_pin_a_i), .pin_b(timer_pin_b_i));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // --------------------------------
  // bus and compare tasks
  // --------------------------------
  // the leading edge keeps back-to-back calls from double driving psel
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, err);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, rd, err);
    chk(rd, exp);
  endtask
  task automatic final_report();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    final_report();
  end

  // --------------------------------
  // main sequence
  // --------------------------------
  initial begin
    {psel, penable, pwrite} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    n_errors = 0;
    check_count = 0;
    presetn = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d, rd, err);
      chk({31'h0, err}, {31'h0, rows[i].e});
      rdc(rows[i].a, rows[i].q);
    end
    // pwm with toggling: intervals are (reload + 1) ticks
    wr(OFS_RELOAD_A, 32'h2);
    wr(OFS_RELOAD_B, 32'h4);
    wr(OFS_COUNT, 32'h0);
    wr(OFS_CTRL, 32'hb0);
    @(timer_pin_a_o);
    for (int k = 0; k < 2; k++) begin
      t0 = $realtime;
      @(timer_pin_a_o);
      chk(int'(($realtime - t0) / 5.0), k ? 32'h14 : 32'h0c);
    end
    rdc(OFS_CTRL, 32'hba);
    wr(OFS_CTRL, 32'h80);
    apb(1'b0, OFS_COUNT, 32'h0, keep, err);
    repeat (12) @(posedge pclk);
    rdc(OFS_COUNT, keep);
    chk({31'h0, timer_pin_a_oe}, 32'h0);
    // event counting on pin a, pin b as plain interrupt input
    wr(OFS_COUNT, 32'h1);
    wr(OFS_RELOAD_A, 32'h5);
    wr(OFS_CTRL, 32'h15);
    u_pins.set_pins(1'b1, 1'b0);
    rdc(OFS_COUNT, 32'h0);
    u_pins.set_pins(1'b0, 1'b0);
    u_pins.set_pins(1'b1, 1'b0);
    rdc(OFS_COUNT, 32'h5);
    chk({30'h0, irq_b, irq_a}, 32'h1);
    u_pins.set_pins(1'b1, 1'b1);
    chk({30'h0, irq_b, irq_a}, 32'h3);
    chk({31'h0, timer_pin_a_oe}, 32'h0);
    rdc(OFS_CTRL, 32'h1f);
    wr(OFS_CTRL, 32'h1b);
    repeat (3) @(posedge pclk);
    chk({30'h0, irq_b, irq_a}, 32'h2);
    wr(OFS_CTRL, 32'h30);
    u_pins.set_pins(1'b0, 1'b1);
    u_pins.set_pins(1'b1, 1'b1);
    rdc(OFS_COUNT, 32'h4);
    // capture: every capture mode, rising edges first then falling edges
    wr(OFS_CTRL, 32'h0);
    u_pins.set_pins(1'b0, 1'b0);
    wr(OFS_COUNT, 32'h8000);
    foreach (caps[i]) begin
      fa = caps[i][0];
      fb = caps[i][2] | caps[i][0];
      wr(OFS_CTRL, {24'h0, caps[i], 5'h00});
      u_pins.set_pins(1'b1, 1'b1);
      rdc(OFS_CTRL, {24'h0, caps[i], 1'b0, !fa, 1'b0, !fb, 1'b0});
      wr(OFS_CTRL, {24'h0, caps[i], 5'h00});
      u_pins.set_pins(1'b0, 1'b0);
      rdc(OFS_CTRL, {24'h0, caps[i], 1'b0, fa, 1'b0, fb, 1'b0});
    end
    wr(OFS_CTRL, 32'h40);
    apb(1'b0, OFS_COUNT, 32'h0, keep, err);
    u_pins.set_pins(1'b1, 1'b0);
    apb(1'b0, OFS_COUNT, 32'h0, rd, err);
    chk({31'h0, rd < keep}, 32'h1);
    fa = rd < keep;
    apb(1'b0, OFS_RELOAD_A, 32'h0, pwdata, err);
    chk({31'h0, pwdata <= keep && pwdata >= rd}, 32'h1);
    // capture underflow lands in the run bit and raises irq a
    wr(OFS_CTRL, 32'h44);
    wr(OFS_COUNT, 32'h2);
    repeat (24) @(posedge pclk);
    chk({30'h0, irq_b, irq_a}, 32'h1);
    rdc(OFS_CTRL, 32'h54);
    apb(1'b0, OFS_COUNT, 32'h0, rd, err);
    chk({31'h0, rd > 32'hff00}, 32'h1);
    // reset in mid-run
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdc(OFS_CTRL, 32'h0);
    rdc(OFS_COUNT, 32'h0);
    final_report();
  end
endmodule
